//--- boot_block_stream_loader.sv
// Boot block stream parser and memory filler
// Operation
// - Each block begins with a header describing type, length and placement.
// - Header word one holds the tag in bits 0-15; upper bits ignored.
// - Header word two holds start address 16-47 and word count 0-15.
// - Zero blocks write count zeros from start address, reading no body.
// - Init blocks store count 48-bit body words from start address.
// - Tags are 16 bits; zero and init codes as listed.
// - Each tag selects data or program memory and a word width.
// - Final-init tag reads one more word held for the holding register.
// - Final step overwrites kernel region and restores control registers to defaults.
// - User code starts at the second reset-vector location.
// - Headers are read through the port chosen by boot mode.
// - Initialise generators, interrupts, identity and wait states before loading; the code only waits in a setup phase shown on setupActive.
`include "boot_loader_cfg.svh"
`default_nettype none
module boot_block_stream_loader
	import boot_loader_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic useLinkPort,
	input wire logic extValid,
	input wire logic [47:0] extData,
	input wire logic linkValid,
	input wire logic [47:0] linkData,
	output logic streamReady,
	output logic memWrite,
	output logic memSpace,
	output logic [2:0] memWidth,
	output logic [31:0] memAddr,
	output logic [47:0] memData,
	output logic setupActive,
	output logic restoreDefaults,
	output logic [47:0] final_instruction_holding_reg,
	output logic startUser,
	output logic [31:0] userStartAddr,
	output logic bootDone,
	output logic bootError
);
	boot_word_if word ();

	boot_port_select portSel (
		.clk_sys(clk_sys),
		.rst(rst),
		.useLinkPort(useLinkPort),
		.extValid(extValid),
		.extData(extData),
		.linkValid(linkValid),
		.linkData(linkData),
		.word(word)
	);

	state_t state_reg, state_next;
	logic [3:0] setupCnt_reg, setupCnt_next;
	logic [15:0] tag_reg, tag_next;
	logic [15:0] count_reg, count_next;
	logic [31:0] addr_reg, addr_next;
	logic [47:0] hold_reg, hold_next;
	logic ready_reg, ready_next;
	logic wr_reg, wr_next;
	logic space_reg, space_next;
	width_t width_reg, width_next;
	logic [31:0] wAddr_reg, wAddr_next;
	logic [47:0] wData_reg, wData_next;
	logic restore_reg, restore_next;
	logic start_reg, start_next;
	logic done_reg, done_next;
	logic err_reg, err_next;
	logic tagKnown;
	logic tagZero;
	space_t tagSpace;
	width_t tagWidth;
	logic take;

	assign take = word.valid & ready_reg;
	assign word.ready = ready_reg;

	// Tag decode
	always_comb begin
		tagKnown = 1'b1;
		tagZero = 1'b0;
		tagSpace = SPACE_DM;
		tagWidth = WIDTH_16;
		case (word.data[`TAG_MSB:`TAG_LSB])
			`TAG_ZERO_DM16: begin tagZero = 1'b1; end
			`TAG_ZERO_DM32: begin tagZero = 1'b1; tagWidth = WIDTH_32; end
			`TAG_ZERO_DM40: begin tagZero = 1'b1; tagWidth = WIDTH_40; end
			`TAG_INIT_DM16: begin end
			`TAG_INIT_DM32: begin tagWidth = WIDTH_32; end
			`TAG_ZERO_PM16: begin tagZero = 1'b1; tagSpace = SPACE_PM; end
			`TAG_ZERO_PM32: begin
				tagZero = 1'b1; tagSpace = SPACE_PM; tagWidth = WIDTH_32;
			end
			`TAG_ZERO_PM40: begin
				tagZero = 1'b1; tagSpace = SPACE_PM; tagWidth = WIDTH_40;
			end
			`TAG_ZERO_PM48: begin
				tagZero = 1'b1; tagSpace = SPACE_PM; tagWidth = WIDTH_48;
			end
			`TAG_INIT_PM16: begin tagSpace = SPACE_PM; end
			`TAG_INIT_PM32: begin tagSpace = SPACE_PM; tagWidth = WIDTH_32; end
			`TAG_INIT_PM48: begin tagSpace = SPACE_PM; tagWidth = WIDTH_48; end
			`TAG_ZERO_DM64: begin tagZero = 1'b1; tagWidth = WIDTH_64; end
			`TAG_INIT_DM64: begin tagWidth = WIDTH_64; end
			`TAG_ZERO_PM64: begin
				tagZero = 1'b1; tagSpace = SPACE_PM; tagWidth = WIDTH_64;
			end
			`TAG_INIT_PM64: begin tagSpace = SPACE_PM; tagWidth = WIDTH_64; end
			`TAG_FINAL: begin end
			default: begin tagKnown = 1'b0; end
		endcase
	end

	// Sequencer
	always_comb begin
		state_next = state_reg;
		setupCnt_next = setupCnt_reg;
		tag_next = tag_reg;
		count_next = count_reg;
		addr_next = addr_reg;
		hold_next = hold_reg;
		ready_next = 1'b0;
		wr_next = 1'b0;
		space_next = space_reg;
		width_next = width_reg;
		wAddr_next = wAddr_reg;
		wData_next = wData_reg;
		restore_next = 1'b0;
		start_next = 1'b0;
		done_next = done_reg;
		err_next = err_reg;
		case (state_reg)
			ST_SETUP: begin
				setupCnt_next = setupCnt_reg + 4'h1;
				if (setupCnt_reg == `SETUP_CYCLES) begin
					state_next = ST_HDR0;
					ready_next = 1'b1;
				end
			end
			ST_HDR0: begin
				ready_next = 1'b1;
				if (take) begin
					ready_next = 1'b0;
					tag_next = word.data[`TAG_MSB:`TAG_LSB];
					space_next = tagSpace[0];
					width_next = tagWidth;
					if (!tagKnown) begin
						state_next = ST_ERROR;
						err_next = 1'b1;
					end else begin
						state_next = ST_HDR1;
						ready_next = 1'b1;
					end
				end
			end
			ST_HDR1: begin
				ready_next = 1'b1;
				if (take) begin
					ready_next = 1'b0;
					addr_next = word.data[`ADDR_MSB:`ADDR_LSB];
					count_next = word.data[`COUNT_MSB:`COUNT_LSB];
					if (tag_reg == `TAG_FINAL) begin
						state_next = ST_FINAL;
						ready_next = 1'b1;
					end else if (word.data[`COUNT_MSB:`COUNT_LSB] == 16'h0) begin
						state_next = ST_HDR0;
						ready_next = 1'b1;
					end else if (tag_reg == `TAG_ZERO_DM16 || tag_reg == `TAG_ZERO_DM32 ||
						tag_reg == `TAG_ZERO_DM40 || tag_reg == `TAG_ZERO_PM16 ||
						tag_reg == `TAG_ZERO_PM32 || tag_reg == `TAG_ZERO_PM40 ||
						tag_reg == `TAG_ZERO_PM48 || tag_reg == `TAG_ZERO_DM64 ||
						tag_reg == `TAG_ZERO_PM64) begin
						state_next = ST_ZERO;
					end else begin
						state_next = ST_BODY;
						ready_next = 1'b1;
					end
				end
			end
			ST_BODY: begin
				ready_next = 1'b1;
				if (take) begin
					wr_next = 1'b1;
					wAddr_next = addr_reg;
					wData_next = word.data;
					addr_next = addr_reg + 32'h1;
					count_next = count_reg - 16'h1;
					if (count_reg == 16'h1) begin
						state_next = ST_HDR0;
					end
				end
			end
			ST_ZERO: begin
				wr_next = 1'b1;
				wAddr_next = addr_reg;
				wData_next = 48'h0;
				addr_next = addr_reg + 32'h1;
				count_next = count_reg - 16'h1;
				if (count_reg == 16'h1) begin
					state_next = ST_HDR0;
					ready_next = 1'b1;
				end
			end
			ST_FINAL: begin
				ready_next = 1'b1;
				if (take) begin
					ready_next = 1'b0;
					hold_next = word.data;
					addr_next = `KERNEL_BASE;
					count_next = `KERNEL_WORDS;
					space_next = 1'b1; // Program memory
					width_next = WIDTH_48;
					state_next = ST_KERNEL;
					ready_next = 1'b1;
				end
			end
			ST_KERNEL: begin
				ready_next = 1'b1;
				if (take) begin
					wr_next = 1'b1;
					wAddr_next = addr_reg;
					wData_next = word.data;
					addr_next = addr_reg + 32'h1;
					count_next = count_reg - 16'h1;
					if (count_reg == 16'h1) begin
						ready_next = 1'b0;
						restore_next = 1'b1;
						start_next = 1'b1;
						done_next = 1'b1;
						state_next = ST_DONE;
					end
				end
			end
			ST_DONE: begin
			end
			ST_ERROR: begin
				err_next = 1'b1;
			end
			default: begin
				state_next = ST_ERROR;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= ST_SETUP;
			setupCnt_reg <= 4'h0;
			tag_reg <= 16'h0;
			count_reg <= 16'h0;
			addr_reg <= 32'h0;
			hold_reg <= 48'h0;
			ready_reg <= 1'b0;
			wr_reg <= 1'b0;
			space_reg <= 1'b0;
			width_reg <= WIDTH_16;
			wAddr_reg <= 32'h0;
			wData_reg <= 48'h0;
			restore_reg <= 1'b0;
			start_reg <= 1'b0;
			done_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			setupCnt_reg <= setupCnt_next;
			tag_reg <= tag_next;
			count_reg <= count_next;
			addr_reg <= addr_next;
			hold_reg <= hold_next;
			ready_reg <= ready_next;
			wr_reg <= wr_next;
			space_reg <= space_next;
			width_reg <= width_next;
			wAddr_reg <= wAddr_next;
			wData_reg <= wData_next;
			restore_reg <= restore_next;
			start_reg <= start_next;
			done_reg <= done_next;
			err_reg <= err_next;
		end
	end

	logic setup_reg;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			setup_reg <= 1'b1;
		end else begin
			setup_reg <= (state_next == ST_SETUP);
		end
	end

	assign streamReady = ready_reg;
	assign memWrite = wr_reg;
	assign memSpace = space_reg;
	assign memWidth = width_reg;
	assign memAddr = wAddr_reg;
	assign memData = wData_reg;
	assign setupActive = setup_reg;
	assign restoreDefaults = restore_reg;
	assign final_instruction_holding_reg = hold_reg;
	assign startUser = start_reg;
	assign userStartAddr = `RESET_VECTOR + 32'h1;
	assign bootDone = done_reg;
	assign bootError = err_reg;
endmodule // boot_block_stream_loader
`default_nettype wire

//--- boot_loader_assertions.sv
// Port checker for the boot block stream loader
`default_nettype none
module boot_loader_assertions (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic streamReady,
	input wire logic memWrite,
	input wire logic setupActive,
	input wire logic restoreDefaults,
	input wire logic startUser,
	input wire logic [31:0] userStartAddr,
	input wire logic bootDone,
	input wire logic bootError
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence setupEnd;
		$fell(setupActive);
	endsequence
	sequence handOver;
		startUser && restoreDefaults;
	endsequence
	a_setup_quiet: assert property (setupActive |-> !streamReady && !memWrite)
		else $error("ready or write in setup");
	a_setup_ends: assert property ($fell(rst) |-> ##[1:8] !setupActive)
		else $error("setup too long");
	a_ready_after: assert property (setupEnd |-> ##[0:2] streamReady)
		else $error("no ready after setup");
	a_hand_over: assert property (startUser |-> handOver ##1 !(startUser || restoreDefaults))
		else $error("hand-over pulse wrong");
	a_done_follows: assert property (handOver |-> ##[0:2] bootDone)
		else $error("no done after hand-over");
	a_done_sticky: assert property (bootDone |=> bootDone && !streamReady && !memWrite)
		else $error("activity after done");
	a_error_halt: assert property (bootError |=> bootError && !memWrite && !streamReady && !bootDone)
		else $error("activity after error");
	a_user_addr: assert property (userStartAddr == 32'h00020005)
		else $error("user start address wrong");
endmodule // boot_loader_assertions
bind boot_block_stream_loader boot_loader_assertions i_boot_loader_assertions (.clk_sys, .rst,
	.streamReady, .memWrite, .setupActive, .restoreDefaults, .startUser, .userStartAddr,
	.bootDone, .bootError);
`default_nettype wire

//--- boot_loader_cfg.svh
// Constants for the boot block stream loader
`ifndef BOOT_LOADER_CFG_SVH
`define BOOT_LOADER_CFG_SVH
`define TAG_LSB 0
`define TAG_MSB 15
`define COUNT_LSB 0
`define COUNT_MSB 15
`define ADDR_LSB 16
`define ADDR_MSB 47
`define TAG_FINAL 16'h0000
`define TAG_ZERO_DM16 16'h0001
`define TAG_ZERO_DM32 16'h0002
`define TAG_ZERO_DM40 16'h0003
`define TAG_INIT_DM16 16'h0004
`define TAG_INIT_DM32 16'h0005
`define TAG_ZERO_PM16 16'h0007
`define TAG_ZERO_PM32 16'h0008
`define TAG_ZERO_PM40 16'h0009
`define TAG_ZERO_PM48 16'h000A
`define TAG_INIT_PM16 16'h000B
`define TAG_INIT_PM32 16'h000C
`define TAG_INIT_PM48 16'h000E
`define TAG_ZERO_DM64 16'h000F
`define TAG_INIT_DM64 16'h0010
`define TAG_ZERO_PM64 16'h0011
`define TAG_INIT_PM64 16'h0012
`define SETUP_CYCLES 4'h4
`define KERNEL_BASE 32'h00000000
`define KERNEL_WORDS 16'h0100
`define RESET_VECTOR 32'h00020004
`endif

//--- boot_loader_pkg.sv
// Types for the boot block stream loader
`default_nettype none
package boot_loader_pkg;
	typedef enum logic [1:0] {
		SPACE_DM = 2'h0,
		SPACE_PM = 2'h1
	} space_t;
	typedef enum logic [2:0] {
		WIDTH_16 = 3'h0,
		WIDTH_32 = 3'h1,
		WIDTH_40 = 3'h2,
		WIDTH_48 = 3'h3,
		WIDTH_64 = 3'h4
	} width_t;
	typedef enum logic [3:0] {
		ST_SETUP = 4'h0,
		ST_HDR0 = 4'h1,
		ST_HDR1 = 4'h2,
		ST_BODY = 4'h3,
		ST_ZERO = 4'h4,
		ST_FINAL = 4'h5,
		ST_KERNEL = 4'h6,
		ST_DONE = 4'h7,
		ST_ERROR = 4'h8
	} state_t;
endpackage
`default_nettype wire

//--- boot_port_select.sv
// Boot port selection and synchronisation of incoming stream words
`default_nettype none
module boot_port_select (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic useLinkPort,
	input wire logic extValid,
	input wire logic [47:0] extData,
	input wire logic linkValid,
	input wire logic [47:0] linkData,
	boot_word_if.source word
);
	logic [1:0] selSync_reg;
	logic [1:0] selSync_next;
	logic selValid_reg;
	logic selValid_next;
	logic [47:0] selData_reg;
	logic [47:0] selData_next;
	logic lastTog_reg;
	logic lastTog_next;

	// Selected port strobe and data
	always_comb begin
		selSync_next = {selSync_reg[0], useLinkPort};
		selValid_next = selSync_reg[1] ? linkValid : extValid;
		selData_next = selSync_reg[1] ? linkData : extData;
		lastTog_next = selValid_reg & word.ready;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			selSync_reg <= 2'h0;
			selValid_reg <= 1'b0;
			selData_reg <= 48'h0;
			lastTog_reg <= 1'b0;
		end else begin
			selSync_reg <= selSync_next;
			selValid_reg <= selValid_next;
			selData_reg <= selData_next;
			lastTog_reg <= lastTog_next;
		end
	end

	assign word.valid = selValid_reg & ~lastTog_reg;
	assign word.data = selData_reg;
endmodule // boot_port_select
`default_nettype wire

//--- boot_source_model.sv
// Boot source offering stream words on the selected port
`default_nettype none
module boot_source_model (
	input wire logic clk_sys,
	input wire logic useLinkPort,
	input wire logic streamReady,
	output logic extValid,
	output logic [47:0] extData,
	output logic linkValid,
	output logic [47:0] linkData
);
	timeunit 1ns;
	timeprecision 1ns;
	logic offer = 1'b0;
	logic [47:0] word = 48'h0;
	logic [47:0] pat = 48'h0;
	// Released lines show a changing pattern
	always @(posedge clk_sys) pat <= pat + 48'h1;
	assign extValid = offer && !useLinkPort;
	assign linkValid = offer && useLinkPort;
	assign extData = extValid ? word : pat;
	assign linkData = linkValid ? word : ~pat;
	// Hold the word until the edge that takes it
	task automatic sendWord(input logic [47:0] w, input int slow);
		@(posedge clk_sys);
		repeat (slow) @(posedge clk_sys);
		#1;
		word = w;
		offer = 1'b1;
		@(posedge clk_sys);
		do @(negedge clk_sys); while (streamReady !== 1'b1);
		@(posedge clk_sys);
		#1;
		offer = 1'b0;
	endtask
endmodule // boot_source_model
`default_nettype wire

//--- boot_word_if.sv
// Stream word carrier from the port selector to the parser
`default_nettype none
interface boot_word_if;
	logic valid;
	logic ready;
	logic [47:0] data;
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- testbench.sv
// Self-checking testbench for the boot block stream loader
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic useLinkPort = 1'b0;
	logic extValid, linkValid, streamReady, memWrite, memSpace, setupActive;
	logic restoreDefaults, startUser, bootDone, bootError;
	logic [47:0] extData, linkData, memData, holdReg, holdWord;
	logic [2:0] memWidth;
	logic [31:0] memAddr, userStartAddr;
	logic [83:0] expQ[$];
	logic [83:0] want;
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;
	int starts = 0;
	int restores = 0;
	// Arbitrary encodings and vector address for the far-side image
	localparam logic [47:0] returnFromInterruptInstr = 48'h0B3E00000000;
	localparam logic [47:0] idleInstr = 48'h028100000000;
	localparam logic [31:0] portVectorAddr = 32'h00020030;
	// Zero flag, program space, width code per tag; 1F undefined
	logic [4:0] tagInfo [0:18] = '{5'h1F, 5'h10, 5'h11, 5'h12, 5'h00, 5'h01, 5'h1F, 5'h18,
		5'h19, 5'h1A, 5'h1B, 5'h08, 5'h09, 5'h1F, 5'h0B, 5'h14, 5'h04, 5'h1C, 5'h0C};
	always #50 clk_sys = ~clk_sys;
	boot_block_stream_loader i_boot_block_stream_loader (.clk_sys, .rst, .useLinkPort,
		.extValid, .extData, .linkValid, .linkData, .streamReady, .memWrite, .memSpace,
		.memWidth, .memAddr, .memData, .setupActive, .restoreDefaults,
		.final_instruction_holding_reg(holdReg), .startUser, .userStartAddr, .bootDone,
		.bootError);
	boot_source_model i_boot_source_model (.clk_sys, .useLinkPort, .streamReady, .extValid,
		.extData, .linkValid, .linkData);
	task automatic check(input string what, input logic [83:0] seen, input logic [83:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic sendBlock(input logic [15:0] tag, input logic [15:0] cnt);
		logic [4:0] f;
		logic [31:0] a;
		logic [47:0] d;
		f = tagInfo[tag];
		a = $urandom;
		i_boot_source_model.sendWord({$urandom, tag}, $urandom_range(2));
		if (f[4])
			for (int i = 0; i < cnt; i++) expQ.push_back({f[3:0], a + 32'(i), 48'h0});
		i_boot_source_model.sendWord({a, cnt}, $urandom_range(2));
		for (int i = 0; i < cnt && !f[4]; i++) begin
			d = {16'($urandom), $urandom};
			expQ.push_back({f[3:0], a + 32'(i), d});
			i_boot_source_model.sendWord(d, $urandom_range(2));
		end
	endtask
	// One-word init pm48 block at a fixed address
	task automatic sendOne(input logic [31:0] a, input logic [47:0] d);
		expQ.push_back({4'hB, a, d});
		i_boot_source_model.sendWord({32'h0, 16'h000E}, 0);
		i_boot_source_model.sendWord({a, 16'h0001}, 0);
		i_boot_source_model.sendWord(d, 0);
	endtask
	task automatic waitDrain(input string name);
		for (int n = 0; n < 40 && expQ.size() > 0; n++) @(posedge clk_sys);
		check("pending writes", 84'(expQ.size()), 84'h0);
		$display("test %s done", name);
	endtask
	always @(negedge clk_sys) begin
		if (memWrite === 1'b1) begin
			want = expQ.size() > 0 ? expQ.pop_front() : 84'bx;
			check("mem write", {memSpace, memWidth, memAddr, memData}, want);
		end
		if (startUser === 1'b1) starts++;
		if (restoreDefaults === 1'b1) restores++;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			stop_test;
		end
	end
	initial begin
		void'($urandom(32'h6c31));
		repeat (3) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		// Every defined tag except final, port switched halfway, then an empty block
		for (int t = 1; t < 19; t++) begin
			if (t == 10) begin
				useLinkPort = 1'b1;
				// Let the mode pass its two-flop sampler before the next word
				repeat (2) @(posedge clk_sys);
			end
			if (tagInfo[t] != 5'h1F) sendBlock(16'(t), 16'($urandom_range(1, 3)));
		end
		sendBlock(16'h0004, 16'h0000);
		sendOne(portVectorAddr, returnFromInterruptInstr);
		sendOne(32'h00020004, idleInstr);
		waitDrain("blocks");
		// Final init with kernel overwrite
		holdWord = {16'($urandom), $urandom};
		i_boot_source_model.sendWord({$urandom, 16'h0000}, 0);
		i_boot_source_model.sendWord({$urandom, 16'h0000}, 0);
		i_boot_source_model.sendWord(holdWord, 1);
		for (int i = 0; i < 256; i++) begin
			expQ.push_back({4'hB, 32'(i), holdWord ^ 48'(i)});
			i_boot_source_model.sendWord(holdWord ^ 48'(i), 0);
		end
		waitDrain("final");
		repeat (3) @(posedge clk_sys);
		check("done", 84'(bootDone), 84'h1);
		check("starts", 84'(starts), 84'h1);
		check("restores", 84'(restores), 84'h1);
		check("holding", 84'(holdReg), 84'(holdWord));
		check("user start", 84'(userStartAddr), 84'h20005);
		// Undefined tag after a second reset
		#1 rst = 1'b1;
		repeat (3) @(posedge clk_sys);
		#1 rst = 1'b0;
		i_boot_source_model.sendWord({$urandom, 16'h0006}, 0);
		repeat (4) @(posedge clk_sys);
		check("error", 84'({bootError, bootDone}), 84'h2);
		$display("test error done");
		stop_test;
	end
endmodule // testbench
`default_nettype wire
